// file: src/slp_pkg.sv
// Overview of operation
// R01: two-bit field picks control bits per sample: none, overrange, over/underflow, unused.
// R02: five-bit resolution field is read-only and returns thirteen for fourteen bits.
// R03: five-bit total bits per sample field is read-only and returns fifteen.
// R04: five-bit samples per converter per frame field is read-only, returns zero.
// R05: high density format flag, bit seven of format register, always reads zero.
// R06: control words per frame cycle per link field is read-only, always zero.
// R07: two eight-bit spare registers store writes and read back, nothing else; here both also feed the lane checksums.
// R08: lane zero checksum is sum of its link parameters modulo 256, read-only.
// R09: lane one checksum is summed the same way from lane one parameters.
// R10: host keeps the serial control port idle when full conversion performance matters.
// R11: checksum disable control high turns the checksum parameter off, for testing.
// R12: host powers the transmitter down while changing any link configuration field.
// R13: writes to read-only or open bits are ignored; open bits read zero.
// R14: checksums follow every configuration change so reads show current values.
`default_nettype none
package slp_pkg;
   localparam int SLP_ADDR_W = 8;
   // register offsets
   localparam logic [7:0] SLP_OFS_CS_RES = 8'h72;
   localparam logic [7:0] SLP_OFS_NBITS = 8'h73;
   localparam logic [7:0] SLP_OFS_SPF = 8'h74;
   localparam logic [7:0] SLP_OFS_HDCF = 8'h75;
   localparam logic [7:0] SLP_OFS_SPARE1 = 8'h76;
   localparam logic [7:0] SLP_OFS_SPARE2 = 8'h77;
   localparam logic [7:0] SLP_OFS_CKSUM0 = 8'h78;
   localparam logic [7:0] SLP_OFS_CKSUM1 = 8'h79;
   // field positions
   localparam int SLP_CS_HI = 7;
   localparam int SLP_CS_LO = 6;
   localparam int SLP_FLD5_HI = 4;
   localparam int SLP_HD_BIT = 7;
   // reset values
   localparam logic [1:0] SLP_CS_RST = 2'h0;
   localparam logic [7:0] SLP_SPARE_RST = 8'h00;
   localparam logic [7:0] SLP_CKSUM_RST = 8'h00;
   localparam logic [7:0] SLP_RD_RST = 8'h00;
   // fixed link parameters
   localparam logic [1:0] SLP_CS_UNUSED = 2'h3;
   localparam logic [4:0] SLP_RESOLUTION_M1 = 5'h0D;
   localparam logic [4:0] SLP_BITS_M1 = 5'h0F;
   localparam logic [4:0] SLP_SAMPLES_M1 = 5'h00;
   localparam logic SLP_HD_VAL = 1'b0;
   localparam logic [4:0] SLP_CF_VAL = 5'h00;
   localparam int SLP_N_TERMS = 16;
endpackage
`default_nettype wire

// file: src/slp_cksum_sum.sv
`default_nettype none
// modulo 256 sum of a set of parameter bytes
module slp_cksum_sum #(
   parameter int N_TERMS = 16
) (
   input wire logic [N_TERMS-1:0][7:0] i_terms,
   output logic [7:0] o_sum
);
   // eight-bit accumulator wraps naturally
   always_comb begin
      o_sum = 8'h00;
      for (int k = 0; k < N_TERMS; k++) begin
         o_sum = o_sum + i_terms[k]; // R08 R09
      end
   end
endmodule
`default_nettype wire

// file: src/slp_link_param_regs.sv
`default_nettype none
module slp_link_param_regs
   import slp_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic [SLP_ADDR_W-1:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic i_cksum_dis,
   input wire logic [7:0] i_dev_id,
   input wire logic [3:0] i_bank_id,
   input wire logic [4:0] i_lane0_id,
   input wire logic [4:0] i_lane1_id,
   input wire logic i_scrambler_en,
   input wire logic [4:0] i_lanes_m1,
   input wire logic [7:0] i_octets_m1,
   input wire logic [4:0] i_frames_m1,
   input wire logic [7:0] i_converters_m1,
   output logic [7:0] o_rd_data,
   output logic o_rd_hit,
   output logic [1:0] o_ctrl_bits_sel,
   output logic [7:0] o_spare_one,
   output logic [7:0] o_spare_two,
   output logic [7:0] o_lane0_checksum,
   output logic [7:0] o_lane1_checksum
);
   logic [1:0] cs_sel_q;
   logic [7:0] spare1_q;
   logic [7:0] spare2_q;
   logic [7:0] cksum0_q;
   logic [7:0] cksum1_q;
   logic [7:0] rd_data_q;
   logic rd_hit_q;
   logic [7:0] sum0;
   logic [7:0] sum1;
   logic [SLP_N_TERMS-1:0][7:0] lane0_terms;
   logic [SLP_N_TERMS-1:0][7:0] lane1_terms;

   // control bits per sample selection, unused code is refused
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cs_sel_q <= SLP_CS_RST;
      end else if (i_wr_en && i_addr == SLP_OFS_CS_RES &&
                   i_wr_data[SLP_CS_HI:SLP_CS_LO] != SLP_CS_UNUSED) begin
         cs_sel_q <= i_wr_data[SLP_CS_HI:SLP_CS_LO]; // R01 R13
      end
   end

   // spare bytes, stored and also summed into both lane checksums
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         spare1_q <= SLP_SPARE_RST;
         spare2_q <= SLP_SPARE_RST;
      end else if (i_wr_en) begin
         if (i_addr == SLP_OFS_SPARE1) begin
            spare1_q <= i_wr_data; // R07
         end
         if (i_addr == SLP_OFS_SPARE2) begin
            spare2_q <= i_wr_data; // R07
         end
      end
   end

   // parameter bytes per lane, the same for both lanes except the lane id
   assign lane0_terms = {i_dev_id, {4'h0, i_bank_id}, {3'h0, i_lane0_id},
                         {7'h00, i_scrambler_en}, {3'h0, i_lanes_m1}, i_octets_m1,
                         {3'h0, i_frames_m1}, i_converters_m1, {3'h0, SLP_RESOLUTION_M1},
                         {6'h00, cs_sel_q}, {3'h0, SLP_BITS_M1}, {3'h0, SLP_SAMPLES_M1},
                         {7'h00, SLP_HD_VAL}, {3'h0, SLP_CF_VAL}, spare1_q, spare2_q}; // R08
   assign lane1_terms = {i_dev_id, {4'h0, i_bank_id}, {3'h0, i_lane1_id},
                         {7'h00, i_scrambler_en}, {3'h0, i_lanes_m1}, i_octets_m1,
                         {3'h0, i_frames_m1}, i_converters_m1, {3'h0, SLP_RESOLUTION_M1},
                         {6'h00, cs_sel_q}, {3'h0, SLP_BITS_M1}, {3'h0, SLP_SAMPLES_M1},
                         {7'h00, SLP_HD_VAL}, {3'h0, SLP_CF_VAL}, spare1_q, spare2_q}; // R09

   slp_cksum_sum #(.N_TERMS(SLP_N_TERMS)) u_sum_lane0 (
      .i_terms(lane0_terms),
      .o_sum(sum0)
   );

   slp_cksum_sum #(.N_TERMS(SLP_N_TERMS)) u_sum_lane1 (
      .i_terms(lane1_terms),
      .o_sum(sum1)
   );

   // checksums refreshed every cycle, forced to zero when disabled
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cksum0_q <= SLP_CKSUM_RST;
         cksum1_q <= SLP_CKSUM_RST;
      end else if (i_cksum_dis) begin
         cksum0_q <= SLP_CKSUM_RST; // R11
         cksum1_q <= SLP_CKSUM_RST; // R11
      end else begin
         cksum0_q <= sum0; // R08 R14
         cksum1_q <= sum1; // R09 R14
      end
   end

   // registered read port, zero for addresses outside this bank
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rd_data_q <= SLP_RD_RST;
         rd_hit_q <= 1'b0;
      end else if (i_rd_en) begin
         rd_hit_q <= 1'b1;
         unique case (i_addr)
            SLP_OFS_CS_RES: rd_data_q <= {cs_sel_q, 1'b0, SLP_RESOLUTION_M1}; // R02 R13
            SLP_OFS_NBITS: rd_data_q <= {3'h0, SLP_BITS_M1}; // R03
            SLP_OFS_SPF: rd_data_q <= {3'h0, SLP_SAMPLES_M1}; // R04
            SLP_OFS_HDCF: rd_data_q <= {SLP_HD_VAL, 2'h0, SLP_CF_VAL}; // R05 R06
            SLP_OFS_SPARE1: rd_data_q <= spare1_q;
            SLP_OFS_SPARE2: rd_data_q <= spare2_q;
            SLP_OFS_CKSUM0: rd_data_q <= cksum0_q;
            SLP_OFS_CKSUM1: rd_data_q <= cksum1_q;
            default: begin
               rd_data_q <= SLP_RD_RST;
               rd_hit_q <= 1'b0;
            end
         endcase
      end else begin
         rd_hit_q <= 1'b0;
      end
   end

   assign o_rd_data = rd_data_q;
   assign o_rd_hit = rd_hit_q;
   assign o_ctrl_bits_sel = cs_sel_q;
   assign o_spare_one = spare1_q;
   assign o_spare_two = spare2_q;
   assign o_lane0_checksum = cksum0_q;
   assign o_lane1_checksum = cksum1_q;

   // independent reference sums for checking
   logic [7:0] ref0;
   logic [7:0] ref1;
   logic [7:0] ref_common;
   assign ref_common = 8'(i_dev_id + i_bank_id + i_scrambler_en + i_lanes_m1 + i_octets_m1 +
                          i_frames_m1 + i_converters_m1 + 8'h0D + cs_sel_q + 8'h0F +
                          spare1_q + spare2_q);
   assign ref0 = 8'(ref_common + i_lane0_id);
   assign ref1 = 8'(ref_common + i_lane1_id);

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_arst_n);

   sequence s_rd(logic [7:0] a);
      i_rd_en && i_addr == a;
   endsequence

   sequence s_spare1_wr;
      i_wr_en && i_addr == SLP_OFS_SPARE1;
   endsequence

   // second spare write, for the matching round trip
   sequence s_spare2_wr;
      i_wr_en && i_addr == SLP_OFS_SPARE2;
   endsequence

   chk_cs_select_write: assert property ( // R01
      i_wr_en && i_addr == SLP_OFS_CS_RES |=>
         o_ctrl_bits_sel == (($past(i_wr_data[7:6]) == 2'h3) ?
                             $past(o_ctrl_bits_sel) : $past(i_wr_data[7:6])))
      else $error("control bit selection not updated as written");

   chk_resolution_read: assert property ( // R02
      s_rd(SLP_OFS_CS_RES) |=>
         o_rd_data[5:0] == 6'h0D && o_rd_data[7:6] == $past(o_ctrl_bits_sel))
      else $error("resolution field read wrong");

   chk_bits_read: assert property ( // R03
      s_rd(SLP_OFS_NBITS) |=> o_rd_data == 8'h0F && o_rd_hit)
      else $error("total bits per sample read wrong");

   chk_samples_read: assert property ( // R04
      s_rd(SLP_OFS_SPF) |=> o_rd_data == 8'h00 && o_rd_hit)
      else $error("samples per frame read wrong");

   chk_hdcf_read: assert property ( // R05 R06
      s_rd(SLP_OFS_HDCF) |=> o_rd_data == 8'h00 && o_rd_hit)
      else $error("density and control words read wrong");

   // write, one idle cycle, then read back the same byte
   chk_spare_roundtrip: assert property ( // R07
      s_spare1_wr ##1 !i_wr_en ##1 s_rd(SLP_OFS_SPARE1) ##0 !i_wr_en |=>
         o_rd_data == $past(i_wr_data, 3))
      else $error("spare byte did not read back last write");

   chk_spare2_roundtrip: assert property ( // R07
      s_spare2_wr ##1 !i_wr_en ##1 s_rd(SLP_OFS_SPARE2) ##0 !i_wr_en |=>
         o_rd_data == $past(i_wr_data, 3))
      else $error("second spare byte did not read back last write");

   chk_spare_isolated: assert property ( // R13
      i_wr_en && i_addr != SLP_OFS_SPARE1 && i_addr != SLP_OFS_SPARE2 |=>
         $stable(o_spare_one) && $stable(o_spare_two))
      else $error("spare changed on unrelated write");

   chk_lane0_sum: assert property ( // R08
      !i_cksum_dis |=> o_lane0_checksum == $past(ref0))
      else $error("lane zero checksum mismatch");

   chk_lane1_sum: assert property ( // R09
      !i_cksum_dis |=> o_lane1_checksum == $past(ref1))
      else $error("lane one checksum mismatch");

   chk_cksum_disable: assert property ( // R11
      i_cksum_dis [*2] |-> o_lane0_checksum == 8'h00 && o_lane1_checksum == 8'h00)
      else $error("checksum not cleared while disabled");

   chk_cksum_read: assert property ( // R14
      s_rd(SLP_OFS_CKSUM1) |=> o_rd_data == $past(o_lane1_checksum))
      else $error("checksum read stale");

   // reads outside the bank return zero with no hit
   chk_unmapped_read: assert property ( // R13
      i_rd_en && (i_addr < SLP_OFS_CS_RES || i_addr > SLP_OFS_CKSUM1) |=>
         o_rd_data == 8'h00 && !o_rd_hit)
      else $error("unmapped read gave data or hit");

   // a hit only ever follows a read of a mapped address
   chk_hit_mapped: assert property ( // R13
      o_rd_hit |-> $past(i_rd_en) && $past(i_addr) >= SLP_OFS_CS_RES &&
         $past(i_addr) <= SLP_OFS_CKSUM1)
      else $error("read hit without a mapped read");
endmodule
`default_nettype wire

// file: dv/slp_link_peer.sv
`default_nettype none
// link side parameter source, new set only when stepped
module slp_link_peer (
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_step,
   output logic [7:0] o_dev,
   output logic [3:0] o_bank,
   output logic [4:0] o_lid0,
   output logic [4:0] o_lid1,
   output logic o_scr,
   output logic [4:0] o_lanes,
   output logic [7:0] o_oct,
   output logic [4:0] o_frames,
   output logic [7:0] o_conv
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cfg_q;
   // config changes only on a cycle with i_step high
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) cfg_q <= 8'h00;
      else if (i_step) cfg_q <= cfg_q + 8'h5B;
   end
   // large values so the sums wrap
   assign o_dev = 8'hF1 + cfg_q;
   assign o_bank = cfg_q[3:0];
   assign o_lid0 = cfg_q[5:1];
   assign o_lid1 = ~cfg_q[4:0];
   assign o_scr = cfg_q[7];
   assign o_lanes = cfg_q[4:0];
   assign o_oct = 8'hE3 ^ cfg_q;
   assign o_frames = 5'h1F - cfg_q[4:0];
   assign o_conv = cfg_q | 8'h81;
endmodule
`default_nettype wire

// file: dv/slp_link_param_regs_bench.sv
`default_nettype none
module slp_link_param_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import slp_pkg::*;
   logic clk, rst_n, wr_en, rd_en, dis, step, scr, hit;
   logic [7:0] addr, wdata, rd_data, sp1, sp2, ck0, ck1, dev, oct, conv, m_sp1, m_sp2;
   logic [4:0] lid0, lid1, lanes, frames;
   logic [3:0] bank;
   logic [1:0] sel, m_sel;
   int errors, compares;
   slp_link_peer peer (.i_sys_clk(clk), .i_arst_n(rst_n), .i_step(step), .o_dev(dev),
      .o_bank(bank), .o_lid0(lid0), .o_lid1(lid1), .o_scr(scr), .o_lanes(lanes),
      .o_oct(oct), .o_frames(frames), .o_conv(conv));
   slp_link_param_regs DUT (.i_sys_clk(clk), .i_arst_n(rst_n), .i_addr(addr),
      .i_wr_en(wr_en), .i_wr_data(wdata), .i_rd_en(rd_en), .i_cksum_dis(dis),
      .i_dev_id(dev), .i_bank_id(bank), .i_lane0_id(lid0), .i_lane1_id(lid1),
      .i_scrambler_en(scr), .i_lanes_m1(lanes), .i_octets_m1(oct), .i_frames_m1(frames),
      .i_converters_m1(conv), .o_rd_data(rd_data), .o_rd_hit(hit), .o_ctrl_bits_sel(sel),
      .o_spare_one(sp1), .o_spare_two(sp2), .o_lane0_checksum(ck0),
      .o_lane1_checksum(ck1));
   // clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [7:0] exp_sum(input logic [4:0] lid);
      return dev + bank + lid + scr + lanes + oct + frames + conv + 8'h0D + m_sel + 8'h0F
         + m_sp1 + m_sp2;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(posedge clk) #1;
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk) #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge clk) #1;
      rd_en = 1'b0;
      chk(name, rd_data, exp);
      chk("rd_hit", {7'h00, hit}, {7'h00, (a >= 8'h72 && a <= 8'h79)});
   endtask
   task automatic t_fixed();
      rd(8'h72, 8'h0D, "res");
      rd(8'h73, 8'h0F, "nbits");
      rd(8'h74, 8'h00, "spf");
      rd(8'h75, 8'h00, "hdcf");
      rd(8'h76, 8'h00, "spare1_rst");
      rd(8'h80, 8'h00, "unmapped");
   endtask
   task automatic t_ro();
      for (int i = 3; i <= 5; i++) wr(8'h70 + 8'(i), 8'hFF);
      wr(8'h78, 8'hFF);
      wr(8'h79, 8'hFF);
      rd(8'h73, 8'h0F, "nbits_wr");
      rd(8'h74, 8'h00, "spf_wr");
      rd(8'h75, 8'h00, "hdcf_wr");
      rd(8'h78, exp_sum(lid0), "ck0_wr");
   endtask
   task automatic t_sel();
      logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      for (int i = 0; i < 4; i++) begin
         wr(8'h72, {codes[i], 6'h3F});
         if (codes[i] != 2'h3) m_sel = codes[i];
         rd(8'h72, {m_sel, 6'h0D}, "ctrl_sel");
         chk("o_ctrl_bits_sel", {6'h00, sel}, {6'h00, m_sel});
      end
   endtask
   task automatic t_spare();
      wr(8'h76, 8'h5A);
      m_sp1 = 8'h5A;
      rd(8'h76, 8'h5A, "spare1");
      wr(8'h77, 8'hA5);
      m_sp2 = 8'hA5;
      rd(8'h77, 8'hA5, "spare2");
      chk("o_spare_one", sp1, 8'h5A);
      chk("o_spare_two", sp2, 8'hA5);
   endtask
   task automatic t_cksum();
      for (int i = 0; i < 3; i++) begin
         chk("o_lane0_checksum", ck0, exp_sum(lid0));
         chk("o_lane1_checksum", ck1, exp_sum(lid1));
         rd(8'h79, exp_sum(lid1), "ck1_rd");
         step = 1'b1;
         @(posedge clk) #1;
         step = 1'b0;
         @(posedge clk) #1;
      end
      dis = 1'b1;
      @(posedge clk) #1;
      chk("ck0_dis", ck0, 8'h00);
      rd(8'h79, 8'h00, "ck1_dis");
      dis = 1'b0;
      @(posedge clk) #1;
      chk("ck0_back", ck0, exp_sum(lid0));
   endtask
   // reset in mid-run clears every output, then sums come back
   task automatic t_reset();
      rst_n = 1'b0;
      #1;
      chk("sel_rst", {6'h00, sel}, 8'h00);
      chk("spare1_rst", sp1, 8'h00);
      chk("spare2_rst", sp2, 8'h00);
      chk("ck0_rst", ck0, 8'h00);
      chk("ck1_rst", ck1, 8'h00);
      chk("rd_data_rst", rd_data, 8'h00);
      chk("rd_hit_rst", {7'h00, hit}, 8'h00);
      @(posedge clk) #1;
      rst_n = 1'b1;
      {m_sel, m_sp1, m_sp2} = '0;
      @(posedge clk) #1;
      chk("ck0_after_rst", ck0, exp_sum(lid0));
      chk("ck1_after_rst", ck1, exp_sum(lid1));
      rd(8'h77, 8'h00, "spare2_after_rst");
   endtask
   task automatic stop_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // reset, then the scenarios in turn
   initial begin
      rst_n = 1'b0;
      {wr_en, rd_en, dis, step, addr, wdata} = '0;
      {m_sel, m_sp1, m_sp2} = '0;
      errors = 0;
      compares = 0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      t_fixed();
      t_ro();
      t_sel();
      t_spare();
      t_cksum();
      t_reset();
      stop_test();
   end
endmodule
`default_nettype wire
